//--- sctr_regs.vh
`ifndef SCTR_REGS_VH
`define SCTR_REGS_VH

// ==========================================
// register indexes (byte address = index * 4)
`define SCTR_IDX_CLOCK_MODE 6'h03
`define SCTR_IDX_INT_ENABLE 6'h04
`define SCTR_IDX_INT_REQUEST 6'h05
`define SCTR_IDX_TIMER_MODE 6'h06
`define SCTR_IDX_BOUND 6'h09
`define SCTR_IDX_EDGE_SEL 6'h0C
`define SCTR_IDX_INT_CLEAR 6'h20
`define SCTR_IDX_COUNT_LO 6'h21
`define SCTR_IDX_COUNT_HI 6'h22

// ==========================================
// clock_mode fields
`define SCTR_CM_PIN_FN 0
`define SCTR_CM_WDT_EN 1
`define SCTR_CM_LRC_EN 2
`define SCTR_CM_TABLE 3
`define SCTR_CM_HRC_EN 4
`define SCTR_CM_SYS_LO 5
`define SCTR_CM_SYS_HI 7

// ==========================================
// timer_mode fields and edge select
`define SCTR_TM_ISEL_HI 2
`define SCTR_TM_PDIV_LO 3
`define SCTR_TM_PDIV_HI 4
`define SCTR_TM_SRC_LO 5
`define SCTR_TM_SRC_HI 7
`define SCTR_ES_TIMER 4

// ==========================================
// reset values and interrupt mask
`define SCTR_CLOCK_MODE_RST 8'hF6
`define SCTR_INT_ENABLE_RST 8'h00
`define SCTR_TIMER_MODE_RST 8'h00
`define SCTR_BOUND_RST 8'h00
`define SCTR_EDGE_SEL_RST 8'h00
`define SCTR_INT_MASK 8'hDF

// ==========================================
// interrupt bit positions
`define SCTR_INT_PIN_A 0
`define SCTR_INT_PIN_B 1
`define SCTR_INT_TIMER 2
`define SCTR_INT_ADC 3
`define SCTR_INT_CMP 4
`define SCTR_INT_TMR_A 6
`define SCTR_INT_TMR_B 7

// ==========================================
// timer clock source codes
`define SCTR_TSRC_OFF 3'h0
`define SCTR_TSRC_SYS 3'h1
`define SCTR_TSRC_RSV 3'h2
`define SCTR_TSRC_PIN4 3'h3
`define SCTR_TSRC_HRC 3'h4
`define SCTR_TSRC_EXT 3'h5
`define SCTR_TSRC_LRC 3'h6
`define SCTR_TSRC_PIN0 3'h7

// ==========================================
// system clock source codes
`define SCTR_SRC_HRC 2'h0
`define SCTR_SRC_EXT 2'h1
`define SCTR_SRC_LRC 2'h2

`endif

//--- sctr_sync.v
`timescale 1ns/100ps

// ==========================================
// three-stage pin synchroniser
// the output moves only once stages two and three agree
module sctr_sync (
    input wire pclk,
    input wire presetn,
    input wire pin_in,
    output reg level_r
);

reg s1_r;
reg s2_r;
reg s3_r;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        level_r <= 1'b0;
    end else begin
        s1_r <= pin_in;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end
end

endmodule

//--- sctr_top.v
// Chosen here: the APB slave port.
`timescale 1ns/100ps


`include "sctr_regs.vh"

module sctr_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_r,
    output reg pready_r,
    output reg pslverr_r,
    input wire high_rc_osc,
    input wire ext_osc,
    input wire low_rc_osc,
    input wire sys_clk_tick,
    input wire port_a_pin4,
    input wire port_a_pin0,
    input wire bound_timer_b_evt,
    input wire bound_timer_a_evt,
    input wire comparator_evt,
    input wire adc_evt,
    input wire pin_b0_a4_evt,
    input wire pin_a0_b5_evt,
    output reg [1:0] sys_clk_src_r,
    output reg [2:0] sys_clk_div_log2_r,
    output reg sys_clk_sel_bad_r,
    output reg high_rc_osc_en_r,
    output reg low_rc_osc_en_r,
    output reg watchdog_run_r,
    output reg external_reset_pin_sel_r,
    output reg [7:0] second_timer_bound_r,
    output reg [15:0] timer_count_r,
    output reg irq_r
);

// ==========================================
// decode helpers

// result is {reserved, source[1:0], log2 divide[2:0]}
function [5:0] sysclk_decode;
    input tbl;
    input [2:0] sel;
    begin
        if (!tbl) begin
            case (sel)
                3'h0: sysclk_decode = {1'b0, `SCTR_SRC_HRC, 3'h2};
                3'h1: sysclk_decode = {1'b0, `SCTR_SRC_HRC, 3'h1};
                3'h2: sysclk_decode = {1'b1, `SCTR_SRC_HRC, 3'h0};
                3'h3: sysclk_decode = {1'b0, `SCTR_SRC_EXT, 3'h2};
                3'h4: sysclk_decode = {1'b0, `SCTR_SRC_EXT, 3'h1};
                3'h5: sysclk_decode = {1'b0, `SCTR_SRC_EXT, 3'h0};
                3'h6: sysclk_decode = {1'b0, `SCTR_SRC_LRC, 3'h2};
                default: sysclk_decode = {1'b0, `SCTR_SRC_LRC, 3'h0};
            endcase
        end else begin
            case (sel)
                3'h0: sysclk_decode = {1'b0, `SCTR_SRC_HRC, 3'h4};
                3'h1: sysclk_decode = {1'b0, `SCTR_SRC_HRC, 3'h3};
                3'h2: sysclk_decode = {1'b0, `SCTR_SRC_LRC, 3'h4};
                3'h3: sysclk_decode = {1'b0, `SCTR_SRC_HRC, 3'h5};
                3'h4: sysclk_decode = {1'b0, `SCTR_SRC_HRC, 3'h6};
                3'h5: sysclk_decode = {1'b0, `SCTR_SRC_EXT, 3'h3};
                default: sysclk_decode = {1'b1, `SCTR_SRC_HRC, 3'h0};
            endcase
        end
    end
endfunction

// last prescaler count before a tick passes
function [5:0] pdiv_last;
    input [1:0] code;
    begin
        case (code)
            2'h0: pdiv_last = 6'h00;
            2'h1: pdiv_last = 6'h03;
            2'h2: pdiv_last = 6'h0F;
            default: pdiv_last = 6'h3F;
        endcase
    end
endfunction

// word index from a byte address; low two bits ignored
function [5:0] reg_index;
    input [7:0] addr;
    begin
        reg_index = addr[7:2];
    end
endfunction

// ==========================================
// registers and wires

reg [7:0] clock_mode_r;
reg [7:0] interrupt_enable_r;
reg [7:0] interrupt_request_r;
reg [7:0] interrupt_request_nxt;
reg [7:0] timer_mode_r;
reg [7:0] edge_sel_r;
reg [5:0] pdiv_cnt_r;
reg [5:0] pdiv_cnt_nxt;
reg [15:0] timer_count_nxt;
reg hrc_prev_r;
reg ext_prev_r;
reg lrc_prev_r;
reg pin4_prev_r;
reg pin0_prev_r;
reg src_tick;
reg count_tick;
reg timer_evt;
reg [31:0] rdata;
reg addr_ok;

wire hrc_lvl;
wire ext_lvl;
wire lrc_lvl;
wire pin4_lvl;
wire pin0_lvl;
wire [5:0] sys_dec;
wire [2:0] tsrc;
wire [2:0] isel;
wire [15:0] count_inc;
wire cur_bit;
wire inc_bit;
wire [5:0] idx;
wire bus_done;
wire wr_en;
wire [7:0] wbyte;
wire [7:0] set_vec;

// ==========================================
// input synchronisers

sctr_sync u_sync_hrc (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(high_rc_osc),
    .level_r(hrc_lvl)
);

sctr_sync u_sync_ext (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(ext_osc),
    .level_r(ext_lvl)
);

sctr_sync u_sync_lrc (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(low_rc_osc),
    .level_r(lrc_lvl)
);

sctr_sync u_sync_pin4 (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(port_a_pin4),
    .level_r(pin4_lvl)
);

sctr_sync u_sync_pin0 (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(port_a_pin0),
    .level_r(pin0_lvl)
);

// ==========================================
// apb slave: one wait state, pready from a flop

assign idx = reg_index(paddr);
assign bus_done = psel & penable & pready_r;
assign wr_en = bus_done & pwrite;
assign wbyte = pwdata[7:0];

always @* begin
    addr_ok = 1'b1;
    rdata = 32'h0000_0000;
    case (idx)
        `SCTR_IDX_CLOCK_MODE: rdata[7:0] = clock_mode_r;
        `SCTR_IDX_INT_ENABLE: rdata[7:0] = interrupt_enable_r;
        `SCTR_IDX_INT_REQUEST: rdata[7:0] = interrupt_request_r;
        `SCTR_IDX_TIMER_MODE: rdata[7:0] = timer_mode_r;
        `SCTR_IDX_BOUND: rdata[7:0] = 8'h00;
        `SCTR_IDX_EDGE_SEL: rdata[7:0] = 8'h00;
        `SCTR_IDX_INT_CLEAR: rdata[7:0] = 8'h00;
        `SCTR_IDX_COUNT_LO: rdata[7:0] = timer_count_r[7:0];
        `SCTR_IDX_COUNT_HI: rdata[7:0] = timer_count_r[15:8];
        default: addr_ok = 1'b0;
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
        prdata_r <= 32'h0000_0000;
    end else if (psel && penable && !pready_r) begin
        pready_r <= 1'b1;
        pslverr_r <= ~addr_ok;
        prdata_r <= (pwrite || !addr_ok) ? 32'h0000_0000 : rdata;
    end else begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
    end
end

// ==========================================
// configuration registers

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        clock_mode_r <= `SCTR_CLOCK_MODE_RST;
        interrupt_enable_r <= `SCTR_INT_ENABLE_RST;
        timer_mode_r <= `SCTR_TIMER_MODE_RST;
        edge_sel_r <= `SCTR_EDGE_SEL_RST;
        second_timer_bound_r <= `SCTR_BOUND_RST;
    end else if (wr_en) begin
        case (idx)
            `SCTR_IDX_CLOCK_MODE: clock_mode_r <= wbyte;
            `SCTR_IDX_INT_ENABLE: interrupt_enable_r <= wbyte & `SCTR_INT_MASK;
            `SCTR_IDX_TIMER_MODE: timer_mode_r <= wbyte;
            `SCTR_IDX_EDGE_SEL: edge_sel_r <= wbyte & 8'h1F;
            `SCTR_IDX_BOUND: second_timer_bound_r <= wbyte;
            default: clock_mode_r <= clock_mode_r;
        endcase
    end
end

// ==========================================
// clock control outputs

assign sys_dec = sysclk_decode(clock_mode_r[`SCTR_CM_TABLE],
    clock_mode_r[`SCTR_CM_SYS_HI:`SCTR_CM_SYS_LO]);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sys_clk_src_r <= `SCTR_SRC_LRC;
        sys_clk_div_log2_r <= 3'h0;
        sys_clk_sel_bad_r <= 1'b0;
        high_rc_osc_en_r <= 1'b1;
        low_rc_osc_en_r <= 1'b1;
        watchdog_run_r <= 1'b1;
        external_reset_pin_sel_r <= 1'b0;
    end else begin
        sys_clk_sel_bad_r <= sys_dec[5];
        sys_clk_src_r <= sys_dec[4:3];
        sys_clk_div_log2_r <= sys_dec[2:0];
        high_rc_osc_en_r <= clock_mode_r[`SCTR_CM_HRC_EN];
        low_rc_osc_en_r <= clock_mode_r[`SCTR_CM_LRC_EN];
        // slow RC off starves the watchdog, so its enable is overridden
        watchdog_run_r <= clock_mode_r[`SCTR_CM_WDT_EN] & clock_mode_r[`SCTR_CM_LRC_EN];
        external_reset_pin_sel_r <= clock_mode_r[`SCTR_CM_PIN_FN];
    end
end

// ==========================================
// timer source edges and prescaler

assign tsrc = timer_mode_r[`SCTR_TM_SRC_HI:`SCTR_TM_SRC_LO];

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        hrc_prev_r <= 1'b0;
        ext_prev_r <= 1'b0;
        lrc_prev_r <= 1'b0;
        pin4_prev_r <= 1'b0;
        pin0_prev_r <= 1'b0;
    end else begin
        hrc_prev_r <= hrc_lvl;
        ext_prev_r <= ext_lvl;
        lrc_prev_r <= lrc_lvl;
        pin4_prev_r <= pin4_lvl;
        pin0_prev_r <= pin0_lvl;
    end
end

// oscillators must run well below pclk/4 or edges are lost
always @* begin
    case (tsrc)
        `SCTR_TSRC_SYS: src_tick = sys_clk_tick;
        `SCTR_TSRC_PIN4: src_tick = pin4_prev_r & ~pin4_lvl;
        `SCTR_TSRC_HRC: src_tick = hrc_lvl & ~hrc_prev_r;
        `SCTR_TSRC_EXT: src_tick = ext_lvl & ~ext_prev_r;
        `SCTR_TSRC_LRC: src_tick = lrc_lvl & ~lrc_prev_r;
        `SCTR_TSRC_PIN0: src_tick = pin0_prev_r & ~pin0_lvl;
        default: src_tick = 1'b0;
    endcase
end

always @* begin
    pdiv_cnt_nxt = pdiv_cnt_r;
    count_tick = 1'b0;
    if (src_tick) begin
        if (pdiv_cnt_r >= pdiv_last(timer_mode_r[`SCTR_TM_PDIV_HI:`SCTR_TM_PDIV_LO])) begin
            pdiv_cnt_nxt = 6'h00;
            count_tick = 1'b1;
        end else begin
            pdiv_cnt_nxt = pdiv_cnt_r + 6'h01;
        end
    end
end

// ==========================================
// counter and timer event

assign count_inc = timer_count_r + 16'h0001;
assign isel = timer_mode_r[`SCTR_TM_ISEL_HI:0];
assign cur_bit = timer_count_r[{1'b1, isel}];
assign inc_bit = count_inc[{1'b1, isel}];

always @* begin
    timer_count_nxt = timer_count_r;
    timer_evt = 1'b0;
    if (count_tick) begin
        timer_count_nxt = count_inc;
        if (edge_sel_r[`SCTR_ES_TIMER]) begin
            timer_evt = cur_bit & ~inc_bit;
        end else begin
            timer_evt = ~cur_bit & inc_bit;
        end
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pdiv_cnt_r <= 6'h00;
        timer_count_r <= 16'h0000;
    end else begin
        pdiv_cnt_r <= pdiv_cnt_nxt;
        timer_count_r <= timer_count_nxt;
    end
end

// ==========================================
// interrupt requests

assign set_vec = {bound_timer_b_evt, bound_timer_a_evt, 1'b0, comparator_evt,
    adc_evt, timer_evt, pin_b0_a4_evt, pin_a0_b5_evt};

// a hardware set in the clearing cycle wins
always @* begin
    interrupt_request_nxt = interrupt_request_r;
    if (wr_en && idx == `SCTR_IDX_INT_REQUEST) begin
        interrupt_request_nxt = interrupt_request_r & wbyte;
    end
    if (wr_en && idx == `SCTR_IDX_INT_CLEAR) begin
        interrupt_request_nxt = interrupt_request_r & ~wbyte;
    end
    interrupt_request_nxt = (interrupt_request_nxt | set_vec) & `SCTR_INT_MASK;
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        interrupt_request_r <= 8'h00;
        irq_r <= 1'b0;
    end else begin
        interrupt_request_r <= interrupt_request_nxt;
        irq_r <= |(interrupt_request_nxt & interrupt_enable_r);
    end
end

endmodule

//--- sctr_monitor.sv
`timescale 1ns/100ps

// ==========================================
// port-level checks on the control register bank
module sctr_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata_r,
    input wire pready_r,
    input wire pslverr_r,
    input wire [1:0] sys_clk_src_r,
    input wire [2:0] sys_clk_div_log2_r,
    input wire low_rc_osc_en_r,
    input wire watchdog_run_r,
    input wire [15:0] timer_count_r
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // the slave always inserts exactly one wait state
    a_ready_wait: assert property (psel && penable && !pready_r |=> pready_r)
        else $error("ready missing after one wait state");
    a_ready_pulse: assert property (pready_r |=> !pready_r)
        else $error("ready held longer than one cycle");
    a_ready_access: assert property (pready_r |-> psel && penable)
        else $error("ready outside an access phase");
    a_err_ready: assert property (pslverr_r |-> pready_r)
        else $error("error without ready");
    a_rdata_upper: assert property (pready_r |-> prdata_r[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_wdt_gate: assert property (watchdog_run_r |-> low_rc_osc_en_r)
        else $error("watchdog runs with slow oscillator off");
    a_src_div_legal: assert property (sys_clk_src_r != 2'h3 && sys_clk_div_log2_r <= 3'h6)
        else $error("clock source or divider out of range");
    // counter never jumps: any change must be a step of exactly one, so a doubled tick shows here
    a_count_step: assert property (!$stable(timer_count_r) |-> timer_count_r - $past(timer_count_r) == 16'h0001)
        else $error("counter moved by other than one");
endmodule

//--- testbench.sv
`timescale 1ns/100ps
`include "sctr_regs.vh"

module testbench;
    reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tick = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h00000000;
    reg [4:0] osc = 5'h00;
    reg [5:0] evt = 6'h00;
    wire [31:0] prdata_r;
    wire pready_r, pslverr_r, irq_r, hrc, lrc, wd, ext, bad;
    wire [1:0] src;
    wire [2:0] div;
    wire [7:0] bound;
    wire [15:0] cnt;
    integer err_count = 0, checks = 0, i;
    reg [31:0] rd;
    reg re;
    reg [7:0] v;
    reg [15:0] exp_cnt;
    // {bad,src,div} per code, table one above table zero
    localparam [95:0] TAB = {6'h20, 6'h20, 6'h0B, 6'h06, 6'h05, 6'h14, 6'h03, 6'h04,
        6'h10, 6'h12, 6'h08, 6'h09, 6'h0A, 6'h20, 6'h01, 6'h02};
    localparam [17:0] POS = {3'h7, 3'h6, 3'h4, 3'h3, 3'h1, 3'h0};
    localparam [14:0] TSRC = {3'h7, 3'h3, 3'h6, 3'h5, 3'h4};

    always #4 pclk = ~pclk;

    sctr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
        .high_rc_osc(osc[0]), .ext_osc(osc[1]), .low_rc_osc(osc[2]), .sys_clk_tick(tick),
        .port_a_pin4(osc[3]), .port_a_pin0(osc[4]), .bound_timer_b_evt(evt[5]), .bound_timer_a_evt(evt[4]),
        .comparator_evt(evt[3]), .adc_evt(evt[2]), .pin_b0_a4_evt(evt[1]), .pin_a0_b5_evt(evt[0]),
        .sys_clk_src_r(src), .sys_clk_div_log2_r(div), .sys_clk_sel_bad_r(bad), .high_rc_osc_en_r(hrc),
        .low_rc_osc_en_r(lrc), .watchdog_run_r(wd), .external_reset_pin_sel_r(ext),
        .second_timer_bound_r(bound), .timer_count_r(cnt), .irq_r(irq_r));

    // ==========================================
    // checking and closing
    task chk(input string nm, input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("FAIL %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask

    task finish_test;
        begin
            $display("checks %0d mismatches %0d", checks, err_count);
            if (err_count == 0 && checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    // ==========================================
    // bus and stimulus tasks
    task apb(input w, input [5:0] idx, input [31:0] d);
        integer n;
        begin
            n = 0;
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= {idx, 2'b00};
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            do begin
                @(posedge pclk);
                n = n + 1;
            end while (pready_r !== 1'b1 && n < 20);
            rd = prdata_r;
            re = pslverr_r;
            psel <= 1'b0;
            penable <= 1'b0;
            if (n >= 20) begin
                err_count = err_count + 1;
                finish_test;
            end
        end
    endtask

    task wr(input [5:0] idx, input [31:0] d);
        apb(1'b1, idx, d);
    endtask

    task rdc(input string nm, input [5:0] idx, input [31:0] exp);
        begin
            apb(1'b0, idx, 32'h00000000);
            chk(nm, rd, exp);
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge pclk);
    endtask

    task ticks(input integer n);
        repeat (n) begin
            @(posedge pclk) tick <= 1'b1;
            @(posedge pclk) tick <= 1'b0;
        end
    endtask

    // slow square wave, one rising and one falling edge per period
    task wave(input integer k, input integer n);
        repeat (n) begin
            @(posedge pclk) osc[k] <= 1'b1;
            cyc(9);
            @(posedge pclk) osc[k] <= 1'b0;
            cyc(9);
        end
    endtask

    // ==========================================
    // main sequence
    initial begin
        cyc(16);
        presetn <= 1'b1;
        rdc("clock_mode", `SCTR_IDX_CLOCK_MODE, 32'hF6);
        rdc("int_enable", `SCTR_IDX_INT_ENABLE, 32'h00);
        rdc("int_request", `SCTR_IDX_INT_REQUEST, 32'h00);
        rdc("timer_mode", `SCTR_IDX_TIMER_MODE, 32'h00);
        chk("clock_outs", {src, div, bad, hrc, lrc, wd, ext}, {2'h2, 3'h0, 1'b0, 4'hE});
        $display("test reset done");
        for (i = 0; i < 16; i = i + 1) begin
            wr(`SCTR_IDX_CLOCK_MODE, {i[2:0], 1'b1, i[3], 3'h6});
            cyc(3);
            chk("clk_bad", bad, TAB[i*6+5]);
            if (TAB[i*6+5] == 1'b0)
                chk("clk_sel", {src, div}, TAB[i*6 +: 5]);
        end
        for (i = 0; i < 16; i = i + 1) begin
            v = {3'h7, i[3], 1'b0, i[2:0]};
            wr(`SCTR_IDX_CLOCK_MODE, v);
            cyc(3);
            chk("clk_bits", {hrc, lrc, wd, ext}, {i[3], i[2], i[2] & i[1], i[0]});
            rdc("clock_mode", `SCTR_IDX_CLOCK_MODE, v);
        end
        wr(`SCTR_IDX_CLOCK_MODE, 32'hF6);
        $display("test clock mode done");
        wr(`SCTR_IDX_BOUND, 32'hA5);
        rdc("bound_read", `SCTR_IDX_BOUND, 32'h00);
        chk("bound_out", bound, 32'hA5);
        apb(1'b0, 6'h3F, 32'h00000000);
        chk("unmapped_err", re, 1'b1);
        chk("unmapped_data", rd, 32'h00);
        $display("test map done");
        wr(`SCTR_IDX_INT_ENABLE, 32'hFF);
        rdc("int_enable", `SCTR_IDX_INT_ENABLE, 32'hDF);
        wr(`SCTR_IDX_INT_ENABLE, 32'h00);
        v = 8'h00;
        for (i = 0; i < 6; i = i + 1) begin
            @(posedge pclk) evt[i] <= 1'b1;
            @(posedge pclk) evt[i] <= 1'b0;
            cyc(2);
            v = v | (8'h01 << POS[i*3 +: 3]);
            chk("irq_masked", irq_r, 1'b0);
            rdc("int_request", `SCTR_IDX_INT_REQUEST, v);
        end
        wr(`SCTR_IDX_INT_ENABLE, 32'h08);
        cyc(2);
        chk("irq_on", irq_r, 1'b1);
        wr(`SCTR_IDX_INT_CLEAR, 32'h08);
        cyc(2);
        chk("irq_off", irq_r, 1'b0);
        rdc("int_request", `SCTR_IDX_INT_REQUEST, 32'hD3);
        wr(`SCTR_IDX_INT_REQUEST, 32'h0F);
        rdc("int_request", `SCTR_IDX_INT_REQUEST, 32'h03);
        wr(`SCTR_IDX_INT_CLEAR, 32'hFF);
        $display("test interrupts done");
        wr(`SCTR_IDX_INT_ENABLE, 32'h04);
        wr(`SCTR_IDX_EDGE_SEL, 32'h10);
        wr(`SCTR_IDX_TIMER_MODE, 32'h20);
        ticks(256);
        cyc(6);
        chk("count", cnt, 16'h0100);
        rdc("int_request", `SCTR_IDX_INT_REQUEST, 32'h00);
        ticks(256);
        cyc(6);
        rdc("int_request", `SCTR_IDX_INT_REQUEST, 32'h04);
        chk("irq_timer", irq_r, 1'b1);
        wr(`SCTR_IDX_INT_CLEAR, 32'h04);
        wr(`SCTR_IDX_TIMER_MODE, 32'h21);
        ticks(256);
        cyc(6);
        rdc("int_request", `SCTR_IDX_INT_REQUEST, 32'h00);
        ticks(256);
        cyc(6);
        rdc("int_request", `SCTR_IDX_INT_REQUEST, 32'h04);
        wr(`SCTR_IDX_TIMER_MODE, 32'h30);
        ticks(64);
        cyc(6);
        exp_cnt = 16'h0404;
        rdc("count_lo", `SCTR_IDX_COUNT_LO, exp_cnt[7:0]);
        rdc("count_hi", `SCTR_IDX_COUNT_HI, exp_cnt[15:8]);
        wr(`SCTR_IDX_COUNT_LO, 32'h00);
        for (i = 0; i < 2; i = i + 1) begin
            wr(`SCTR_IDX_TIMER_MODE, {i[0] ? `SCTR_TSRC_RSV : `SCTR_TSRC_OFF, 5'h00});
            ticks(16);
            cyc(6);
            chk("count_stop", cnt, exp_cnt);
        end
        for (i = 0; i < 5; i = i + 1) begin
            wr(`SCTR_IDX_TIMER_MODE, {TSRC[i*3 +: 3], 5'h00});
            wave(i, 3);
            cyc(8);
            exp_cnt = exp_cnt + 16'h0003;
            chk("count_src", cnt, exp_cnt);
        end
        // a pin source must ignore the rising half of a pulse
        @(posedge pclk) osc[4] <= 1'b1;
        cyc(10);
        chk("pin_rise", cnt, exp_cnt);
        @(posedge pclk) osc[4] <= 1'b0;
        cyc(10);
        exp_cnt = exp_cnt + 16'h0001;
        chk("pin_fall", cnt, exp_cnt);
        wr(`SCTR_IDX_INT_CLEAR, 32'hFF);
        wr(`SCTR_IDX_EDGE_SEL, 32'h00);
        wr(`SCTR_IDX_TIMER_MODE, 32'h20);
        ticks(16'h04FF - exp_cnt);
        cyc(6);
        rdc("int_request", `SCTR_IDX_INT_REQUEST, 32'h00);
        ticks(1);
        cyc(6);
        rdc("int_request", `SCTR_IDX_INT_REQUEST, 32'h04);
        $display("test timer done");
        finish_test;
    end

    // hang guard
    initial begin
        cyc(50000);
        err_count = err_count + 1;
        finish_test;
    end
endmodule

bind sctr_top sctr_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r), .sys_clk_src_r(sys_clk_src_r),
    .sys_clk_div_log2_r(sys_clk_div_log2_r), .low_rc_osc_en_r(low_rc_osc_en_r),
    .watchdog_run_r(watchdog_run_r), .timer_count_r(timer_count_r));
